// File: hw/mabx_pkg.sv
package mabx_pkg;
  // Core clock and cycle budget per instruction
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [2:0] CYC_SHORT = 3'h2;
  localparam logic [2:0] CYC_STD = 3'h4;
  localparam logic [2:0] CYC_BTEST = 3'h5;
  // Instruction lengths in bytes
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  // Data space map
  localparam logic [7:0] PTR_X_ADDR = 8'h80;
  localparam logic [5:0] SHORT_DIR_BASE = 6'h20;
  localparam logic [7:0] ACC_ADDR = 8'hFF;
  // Reset values
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  // Opcode group fields
  localparam logic [3:0] GRP_BTEST = 4'h3;
  localparam logic [3:0] GRP_BITOP = 4'hB;
  localparam logic [3:0] GRP_ACCOP = 4'hD;
  localparam logic [3:0] GRP_CTRL = 4'h5;
  localparam logic [2:0] GRP_JUMP = 3'h1;
  localparam logic [2:0] GRP_SHORT = 3'h5;
  localparam logic [2:0] GRP_MEM = 3'h7;
  // Memory group functions, opcode bits 7:5
  localparam logic [2:0] MEM_COMPARE = 3'h1;
  localparam logic [2:0] MEM_ADD = 3'h2;
  localparam logic [2:0] MEM_INC = 3'h3;
  localparam logic [2:0] MEM_AND = 3'h5;
  localparam logic [2:0] MEM_SUB = 3'h6;
  localparam logic [2:0] MEM_DEC = 3'h7;
  // Accumulator group functions, opcode bits 7:5
  localparam logic [2:0] ACC_COMPLEMENT = 3'h0;
  localparam logic [2:0] ACC_ROTATE = 3'h1;
  localparam logic [2:0] ACC_SHIFT = 3'h2;
  localparam logic [2:0] ACC_CLEAR = 3'h3;
  localparam logic [2:0] ACC_CLEAR_REG = 3'h4;
  // Control group functions, opcode bits 7:5
  localparam logic [2:0] CTL_RETURN = 3'h1;
  localparam logic [2:0] CTL_INT_RETURN = 3'h2;
  localparam logic [2:0] CTL_STOP = 3'h3;
  localparam logic [2:0] CTL_WAIT = 3'h4;
  // ALU operations
  typedef enum logic [3:0] {
    ALU_PASS = 4'h0, ALU_ADD = 4'h1, ALU_SUB = 4'h2, ALU_AND = 4'h3,
    ALU_INC = 4'h4, ALU_DEC = 4'h5, ALU_COM = 4'h6, ALU_RLC = 4'h7,
    ALU_SLA = 4'h8, ALU_CLR = 4'h9
  } mabx_alu_e;
  // Execution sequencer states
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001, ST_RUN = 3'b010, ST_EXEC = 3'b100
  } mabx_state_e;
endpackage : mabx_pkg

// File: hw/mabx_alu.sv
`timescale 1ns/1ps
`default_nettype none
module mabx_alu
  import mabx_pkg::*;
(
  // Operation and operands
  input wire mabx_alu_e fn,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  // Result
  output logic [7:0] result,
  output logic carryOut
);
  logic [8:0] wide;

  // Eight-bit datapath with carry or borrow out
  always_comb begin
    wide = {carryIn, opA};
    case (fn)
      ALU_ADD: wide = {1'b0, opA} + {1'b0, opB};
      ALU_SUB: wide = {1'b0, opA} - {1'b0, opB}; // Borrow in bit 8
      ALU_AND: wide = {1'b0, opA & opB};
      ALU_INC: wide = {carryIn, opA + 8'h01}; // Carry kept
      ALU_DEC: wide = {carryIn, opA - 8'h01};
      ALU_COM: wide = {opA[7], ~opA};
      ALU_RLC: wide = {opA, carryIn};
      ALU_SLA: wide = {opA, 1'b0};
      ALU_CLR: wide = 9'h000;
      default: wide = {carryIn, opA};
    endcase
    result = wide[7:0];
    carryOut = wide[8];
  end
endmodule : mabx_alu
`default_nettype wire

// File: hw/mabx_exec.sv
`timescale 1ns/1ps
`default_nettype none
module mabx_exec
  import mabx_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Program memory
  output logic [11:0] progAddr,
  output logic progRe,
  input wire logic [7:0] progData,
  // Data space
  output logic [7:0] dataAddr,
  output logic dataRe,
  output logic dataWe,
  output logic [7:0] dataWdata,
  input wire logic [7:0] dataRdata,
  // Return stack and interrupt context
  output logic pushReq,
  output logic [11:0] pushAddr,
  output logic popReq,
  input wire logic [11:0] returnAddr,
  input wire logic savedZero,
  input wire logic savedCarry,
  // Power modes
  input wire logic watchdogOn,
  output logic stopReq,
  output logic waitReq,
  // Core state
  output logic [11:0] pcValue,
  output logic [7:0] accValue,
  output logic zeroFlag,
  output logic carryFlag,
  output logic instrDone
);
  mabx_state_e state, next_state;
  logic [2:0] cyc;
  logic [7:0] op, b1, b2, ptr, opnd;

  // Cycle count per opcode, used on the raw byte and the held one
  function automatic logic [2:0] opCycles(input logic [7:0] o);
    if (!o[0]) opCycles = CYC_SHORT;
    else if (o[3:0] == GRP_BTEST) opCycles = CYC_BTEST;
    else if (o[3:0] == GRP_CTRL && !o[4]) opCycles = CYC_SHORT;
    else if (o[2:0] == GRP_SHORT && o[5:4] == 2'b11) opCycles = CYC_SHORT;
    else opCycles = CYC_STD;
  endfunction : opCycles

  // Group decode
  wire [2:0] fn3 = op[7:5];
  wire isBr = !op[0];
  wire isJump = op[2:0] == GRP_JUMP;
  wire isCall = isJump && !op[3];
  wire isBtest = op[3:0] == GRP_BTEST;
  wire isBitOp = op[3:0] == GRP_BITOP;
  wire isShort = op[2:0] == GRP_SHORT && op[5:4] == 2'b01;
  wire isAccGrp = op[3:0] == GRP_ACCOP && !op[4];
  wire isCtl = op[3:0] == GRP_CTRL && !op[4];
  wire isMem = op[2:0] == GRP_MEM;
  wire memIncDec = fn3 == MEM_INC || fn3 == MEM_DEC;
  wire memArith = isMem && (fn3 == MEM_COMPARE || fn3 == MEM_ADD
                  || fn3 == MEM_AND || fn3 == MEM_SUB);
  wire memInd = isMem && !op[3];
  wire memImm = memArith && op[3] && op[4];
  wire isCmp = memArith && fn3 == MEM_COMPARE;
  wire accOp = isAccGrp && fn3 <= ACC_CLEAR;
  wire clrReg = isAccGrp && fn3 == ACC_CLEAR_REG;
  wire isRet = isCtl && fn3 == CTL_RETURN;
  wire isReti = isCtl && fn3 == CTL_INT_RETURN;
  wire isStop = isCtl && fn3 == CTL_STOP;
  wire isWait = isCtl && fn3 == CTL_WAIT;
  wire incDec = isShort || (isMem && memIncDec);
  wire [2:0] nCyc = opCycles(op);

  // Length in bytes
  wire [1:0] nBytes = (isBtest || clrReg) ? LEN_THREE :
    (isJump || isBitOp || (isMem && op[3])
     || (isAccGrp && (fn3 == ACC_SHIFT || fn3 == ACC_CLEAR)))
    ? LEN_TWO : LEN_ONE;

  // Effective address and operand source
  wire [7:0] shortAddr = {SHORT_DIR_BASE, op[7:6]};
  wire [7:0] ptrAddr = PTR_X_ADDR | {7'h00, op[4]};
  wire [7:0] ea = isShort ? shortAddr : (memInd ? ptr : b1);
  wire needRead = isShort || isBitOp || isBtest || (isMem && !memImm);
  wire ptrCycle = state == ST_RUN && cyc == 3'h1 && memInd;
  wire opndCycle = state != ST_FETCH && cyc == nCyc - 3'h2;
  wire readCycle = opndCycle && needRead;
  wire exec = state == ST_EXEC;

  // ALU operation select
  wire accSrc = memArith || accOp;
  mabx_alu_e aluFn;
  logic [7:0] aluRes;
  logic aluCarry;
  always_comb begin
    aluFn = ALU_PASS;
    if (isShort) aluFn = op[3] ? ALU_DEC : ALU_INC;
    else if (clrReg) aluFn = ALU_CLR;
    else if (isAccGrp) begin
      case (fn3)
        ACC_COMPLEMENT: aluFn = ALU_COM;
        ACC_ROTATE: aluFn = ALU_RLC;
        ACC_SHIFT: aluFn = ALU_SLA;
        ACC_CLEAR: aluFn = ALU_CLR;
        default: aluFn = ALU_PASS;
      endcase
    end else if (isMem) begin
      case (fn3)
        MEM_COMPARE: aluFn = ALU_SUB;
        MEM_ADD: aluFn = ALU_ADD;
        MEM_INC: aluFn = ALU_INC;
        MEM_AND: aluFn = ALU_AND;
        MEM_SUB: aluFn = ALU_SUB;
        MEM_DEC: aluFn = ALU_DEC;
        default: aluFn = ALU_PASS;
      endcase
    end
  end

  mabx_alu uAlu (
    .fn(aluFn),
    .opA(accSrc ? accValue : opnd),
    .opB(opnd),
    .carryIn(carryFlag),
    .result(aluRes),
    .carryOut(aluCarry)
  );

  // Bit manipulation and test
  wire [2:0] bitIdx = {op[5], op[6], op[7]};
  wire testBit = opnd[bitIdx];
  wire [7:0] bitMask = 8'h01 << bitIdx;
  wire [7:0] bitRes = op[4] ? (opnd | bitMask) : (opnd & ~bitMask);

  // Branch conditions and targets
  wire brCond = op[2] ? (op[1] ? carryFlag : zeroFlag)
                      : (op[1] ? !carryFlag : !zeroFlag);
  wire btCond = testBit == op[4];
  wire [11:0] shortTarget = pcValue + {{7{op[7]}}, op[7:3]}
                            + 12'h001;
  wire [11:0] btTarget = pcValue + {{4{b2[7]}}, b2}
                         + 12'h002;
  wire [11:0] jumpTarget = {op[7:4], b1};
  wire [11:0] seqPc = pcValue + {10'h000, nBytes};
  wire [11:0] next_pc = (isBr && brCond) ? shortTarget :
    (isBtest && btCond) ? btTarget :
    isJump ? jumpTarget : (isRet || isReti) ? returnAddr : seqPc;

  // Result destinations
  wire memDest = isShort || (isMem && memIncDec) || clrReg || isBitOp;
  wire toAcc = memDest && ea == ACC_ADDR && !memInd; // Pointer uses the bus
  wire [7:0] wrValue = isBitOp ? bitRes : aluRes;
  wire accWr = exec && (((memArith && !isCmp) || accOp) || toAcc);
  wire updZ = (memArith || accOp || incDec) && !clrReg;
  wire updC = memArith || accOp;

  // Bus strobes and addresses
  assign progAddr = pcValue + {9'h000, cyc};
  assign progRe = state == ST_FETCH || (cyc == 3'h1 && nBytes != LEN_ONE)
                  || (cyc == 3'h2 && nBytes == LEN_THREE);
  assign dataAddr = ptrCycle ? ptrAddr : ea;
  assign dataRe = ptrCycle || (readCycle && !(ea == ACC_ADDR && !memInd));
  assign dataWe = exec && memDest && !toAcc;
  assign dataWdata = wrValue;
  assign pushReq = exec && isCall;
  assign pushAddr = seqPc;
  assign popReq = exec && (isRet || isReti);
  assign stopReq = exec && isStop && !watchdogOn;
  assign waitReq = exec && (isWait || (isStop && watchdogOn));
  assign instrDone = exec;

  // Sequencer next state
  always_comb begin
    case (state)
      ST_FETCH: next_state = opCycles(progData) == CYC_SHORT
                             ? ST_EXEC : ST_RUN;
      ST_RUN: next_state = (cyc + 3'h2 == nCyc) ? ST_EXEC : ST_RUN;
      ST_EXEC: next_state = ST_FETCH;
      default: next_state = ST_FETCH;
    endcase
  end

  // Sequencer and byte capture
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_FETCH;
      cyc <= 3'h0;
      op <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      ptr <= 8'h00;
      opnd <= 8'h00;
    end else begin
      state <= next_state;
      cyc <= exec ? 3'h0 : cyc + 3'h1;
      if (state == ST_FETCH) op <= progData;
      if (cyc == 3'h1 && nBytes != LEN_ONE) b1 <= progData;
      if (cyc == 3'h2 && nBytes == LEN_THREE) b2 <= progData;
      if (ptrCycle) ptr <= dataRdata;
      if (readCycle || (opndCycle && memImm)) begin
        opnd <= memImm ? b1 : (ea == ACC_ADDR && !memInd)
                            ? accValue : dataRdata;
      end
    end
  end

  // Architectural state update at the last cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pcValue <= PC_RESET;
      accValue <= ACC_RESET;
      zeroFlag <= 1'b0;
      carryFlag <= 1'b0;
    end else if (exec) begin
      pcValue <= next_pc;
      if (accWr) accValue <= wrValue;
      if (updZ) zeroFlag <= aluRes == 8'h00;
      if (updC) carryFlag <= aluCarry;
      if (isBtest) carryFlag <= testBit;
      if (isReti) begin
        zeroFlag <= savedZero;
        carryFlag <= savedCarry;
      end
    end
  end

  // Checks
  AST_CMP_KEEPS_ACC: assert property (@(posedge ref_clk) disable iff (rst)
    exec && isCmp |=> accValue == $past(accValue))
    else $error("compare changed the accumulator");
  AST_INCDEC_CARRY: assert property (@(posedge ref_clk) disable iff (rst)
    exec && incDec |=> carryFlag == $past(carryFlag))
    else $error("increment or decrement touched carry");
  AST_BR_NOT_TAKEN: assert property (@(posedge ref_clk) disable iff (rst)
    exec && isBr && !brCond |=> pcValue == $past(seqPc))
    else $error("untaken branch did not fall through");
  AST_BR_TWO_CYC: assert property (@(posedge ref_clk) disable iff (rst)
    state == ST_FETCH ##1 isBr |-> exec && cyc == 3'h1)
    else $error("short branch not two cycles");
  AST_BTEST_CARRY: assert property (@(posedge ref_clk) disable iff (rst)
    exec && isBtest |=> carryFlag == $past(testBit))
    else $error("tested bit not copied to carry");
  AST_STOP_WD: assert property (@(posedge ref_clk) disable iff (rst)
    exec && isStop && watchdogOn |-> waitReq && !stopReq)
    else $error("stop entered with watchdog selected");
  AST_JUMP_TGT: assert property (@(posedge ref_clk) disable iff (rst)
    exec && isJump |=> pcValue == $past(jumpTarget))
    else $error("jump target wrong");
  AST_FOUR_CYC: assert property (@(posedge ref_clk) disable iff (rst)
    exec && (memArith || accOp || isBitOp) |-> cyc == 3'h3)
    else $error("four cycle instruction length wrong");
  AST_BITOP_FLAGS: assert property (@(posedge ref_clk) disable iff (rst)
    exec && isBitOp |=> $stable(zeroFlag) && $stable(carryFlag))
    else $error("bit set or reset changed flags");
  AST_ZERO_RES: assert property (@(posedge ref_clk) disable iff (rst)
    exec && updZ |=> zeroFlag == ($past(aluRes) == 8'h00))
    else $error("zero flag does not match result");
  COV_BR_TAKEN: cover property (@(posedge ref_clk) exec && isBr && brCond);
  COV_CALL: cover property (@(posedge ref_clk) pushReq);
  COV_STOP_AS_WAIT: cover property (@(posedge ref_clk)
    exec && isStop && watchdogOn);
  COV_BTEST_TAKEN: cover property (@(posedge ref_clk)
    exec && isBtest && btCond);
endmodule : mabx_exec
`default_nettype wire

// File: tb/mabx_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Program memory and data space with zero-latency reads
module mabx_mem (
  // Clock
  input wire logic ref_clk,
  // Program side
  input wire logic [11:0] progAddr,
  input wire logic progRe,
  output logic [7:0] progData,
  // Data side
  input wire logic [7:0] dataAddr,
  input wire logic dataRe,
  input wire logic dataWe,
  input wire logic [7:0] dataWdata,
  output logic [7:0] dataRdata
);
  logic [7:0] prog [4096];
  logic [7:0] data [256];
  // Unqualified reads show a scrambled byte, never the stored one
  assign progData = progRe ? prog[progAddr] : ~prog[progAddr];
  assign dataRdata = dataRe ? data[dataAddr] : ~data[dataAddr];
  // Writes land at the edge closing the strobe cycle
  always @(posedge ref_clk) begin
    if (dataWe === 1'b1) begin
      data[dataAddr] <= dataWdata;
    end
  end
endmodule : mabx_mem
`default_nettype wire

// File: tb/mcu_alu_branch_control_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_alu_branch_control_exec_test import mabx_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] progAddr, pushAddr, returnAddr, pcValue, ePc, wdPc;
  logic [7:0] progData, dataAddr, dataWdata, dataRdata, accValue, eAcc, rnd;
  logic progRe, dataRe, dataWe, pushReq, popReq, savedZero, savedCarry;
  logic watchdogOn, stopReq, waitReq, zeroFlag, carryFlag, instrDone, eZ, eC;
  logic [28:0] notes [$];
  int n_errors = 0;
  int compares = 0;
  // Clock
  always #2.5 ref_clk = ~ref_clk;
  mabx_exec uut (.ref_clk(ref_clk), .rst(rst), .progAddr(progAddr),
    .progRe(progRe), .progData(progData), .dataAddr(dataAddr),
    .dataRe(dataRe), .dataWe(dataWe), .dataWdata(dataWdata),
    .dataRdata(dataRdata), .pushReq(pushReq), .pushAddr(pushAddr),
    .popReq(popReq), .returnAddr(returnAddr), .savedZero(savedZero),
    .savedCarry(savedCarry), .watchdogOn(watchdogOn), .stopReq(stopReq),
    .waitReq(waitReq), .pcValue(pcValue), .accValue(accValue),
    .zeroFlag(zeroFlag), .carryFlag(carryFlag), .instrDone(instrDone));
  mabx_mem mem (.ref_clk(ref_clk), .progAddr(progAddr), .progRe(progRe),
    .progData(progData), .dataAddr(dataAddr), .dataRe(dataRe),
    .dataWe(dataWe), .dataWdata(dataWdata), .dataRdata(dataRdata));
  // Comparison point for every check but the leftover-notes count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Pseudo-random byte source
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Expected accumulator and flags from a 9-bit result
  task automatic setf(input logic [8:0] r);
    eC = r[8];
    eAcc = r[7:0];
    eZ = (r[7:0] == 8'h00);
  endtask : setf
  // Place one instruction and note its expected outcome
  task automatic ins(input logic [23:0] by, input int nb,
      input logic [2:0] cy, input logic [1:0] pw, input int tgt,
      input logic stk = 1'b0);
    for (int i = 0; i < nb; i++) begin
      mem.prog[ePc + i] = by[23 - 8 * i -: 8];
    end
    ePc = (tgt < 0) ? ePc + nb[11:0] : tgt[11:0];
    notes.push_back({ePc, eAcc, eZ, eC, stk, 1'b0, cy, pw});
  endtask : ins
  task automatic tally_and_finish;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog selected only while the marked stop executes
  always @(posedge ref_clk) begin
    #1;
    watchdogOn = (pcValue === wdPc);
  end
  // One-entry return stack: a call's return address comes back on return
  always @(posedge ref_clk) begin
    if (pushReq === 1'b1) begin
      returnAddr <= pushAddr;
    end
  end
  // Output watcher: state, cycles, power and stack requests per instruction
  initial begin : watch
    int cyc;
    logic [1:0] pwSeen;
    logic stkSeen;
    logic [28:0] n;
    cyc = 0;
    pwSeen = 2'b00;
    stkSeen = 1'b0;
    @(negedge rst);
    forever begin
      @(negedge ref_clk);
      cyc++;
      pwSeen = pwSeen | {stopReq === 1'b1, waitReq === 1'b1};
      stkSeen = stkSeen | (pushReq === 1'b1) | (popReq === 1'b1);
      if (instrDone === 1'b1 && notes.size() > 0) begin
        @(posedge ref_clk);
        #1;
        n = notes.pop_front();
        chk({pcValue, accValue, zeroFlag, carryFlag}, n[28:7]);
        chk({stkSeen, cyc[3:0], pwSeen}, n[6:0]);
        cyc = 0;
        pwSeen = 2'b00;
        stkSeen = 1'b0;
      end
    end
  end
  // Program image, expectations and run
  initial begin
    savedZero = 1'b0;
    savedCarry = 1'b1;
    wdPc = 12'hFFF;
    for (int i = 0; i < 4096; i++) begin
      mem.prog[i] = 8'h0D;
    end
    for (int i = 0; i < 256; i++) begin
      mem.data[i] = 8'h00;
    end
    mem.data[8'h10] = 8'hF0;
    mem.data[8'h80] = 8'h20;
    mem.data[8'h20] = 8'hFF;
    mem.data[8'h83] = 8'h7F;
    mem.data[8'h21] = 8'h55;
    ePc = 12'h000;
    eAcc = 8'h00;
    eZ = 1'b0;
    eC = 1'b0;
    rnd = 8'h11;
    rnd = lfsr(rnd);
    setf({1'b0, eAcc} + {1'b0, rnd});
    ins({8'h5F, rnd, 8'h00}, 2, CYC_STD, 2'b00, -1);
    rnd = lfsr(rnd);
    setf({1'b0, eAcc} - {1'b0, rnd});
    ins({8'hDF, rnd, 8'h00}, 2, CYC_STD, 2'b00, -1);
    eZ = 1'b1;
    eC = 1'b0;
    ins({8'h3F, eAcc, 8'h00}, 2, CYC_STD, 2'b00, -1);
    rnd = lfsr(rnd);
    setf({1'b0, eAcc & rnd});
    ins({8'hBF, rnd, 8'h00}, 2, CYC_STD, 2'b00, -1);
    setf({1'b0, eAcc} + 9'h0F0);
    ins({8'h4F, 8'h10, 8'h00}, 2, CYC_STD, 2'b00, -1);
    eZ = 1'b0;
    ins({8'h6F, 8'h10, 8'h00}, 2, CYC_STD, 2'b00, -1);
    eZ = 1'b1;
    ins({8'h67, 16'h0000}, 1, CYC_STD, 2'b00, -1);
    eZ = 1'b0;
    ins({8'hD5, 16'h0000}, 1, CYC_STD, 2'b00, -1);
    setf({eAcc[7], ~eAcc});
    ins({8'h0D, 16'h0000}, 1, CYC_STD, 2'b00, -1);
    setf({eAcc, eC});
    ins({8'h2D, 16'h0000}, 1, CYC_STD, 2'b00, -1);
    setf({eAcc, 1'b0});
    ins({8'h4D, 8'h00, 8'h00}, 2, CYC_STD, 2'b00, -1);
    setf(9'h000);
    ins({8'h6D, 8'h00, 8'h00}, 2, CYC_STD, 2'b00, -1);
    ins({8'h8D, 8'h21, 8'h00}, 3, CYC_STD, 2'b00, -1);
    ins({8'h1C, 16'h0000}, 1, CYC_SHORT, 2'b00, ePc + 4);
    ins({8'h18, 16'h0000}, 1, CYC_SHORT, 2'b00, -1);
    ins({8'h1E, 16'h0000}, 1, CYC_SHORT, 2'b00, -1);
    eC = 1'b1;
    ins({8'h13, 8'h10, 8'h05}, 3, CYC_BTEST, 2'b00, ePc + 7);
    ins({8'h0B, 8'h10, 8'h00}, 2, CYC_STD, 2'b00, -1);
    eC = 1'b0;
    ins({8'h83, 8'h10, 8'h03}, 3, CYC_BTEST, 2'b00, ePc + 5);
    wdPc = ePc;
    ins({8'h65, 16'h0000}, 1, CYC_SHORT, 2'b01, -1);
    ins({8'h65, 16'h0000}, 1, CYC_SHORT, 2'b10, -1);
    ins({8'h31, 8'hA0, 8'h00}, 2, CYC_STD, 2'b00, 12'h3A0, 1'b1);
    eZ = 1'b0;
    eC = 1'b1;
    ins({8'h45, 16'h0000}, 1, CYC_SHORT, 2'b00, 12'h02F, 1'b1);
    ins({8'h39, 8'hB0, 8'h00}, 2, CYC_STD, 2'b00, 12'h3B0);
    ins({8'h31, 8'hC0, 8'h00}, 2, CYC_STD, 2'b00, 12'h3C0, 1'b1);
    ins({8'h25, 16'h0000}, 1, CYC_SHORT, 2'b00, 12'h3B2, 1'b1);
    ins({8'h05, 16'h0000}, 1, CYC_SHORT, 2'b00, -1);
    ins({8'h5D, 16'h0000}, 1, CYC_STD, 2'b00, -1);
    ins({8'h86, 16'h0000}, 1, CYC_SHORT, 2'b00, ePc - 15);
    ins({8'h85, 16'h0000}, 1, CYC_SHORT, 2'b01, -1);
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 3000 && notes.size() > 0; i++) begin
      @(posedge ref_clk);
    end
    if (notes.size() > 0) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, notes.size(), 0);
    end
    chk(mem.data[8'h10], 8'hF0);
    chk(mem.data[8'h20], 8'h00);
    chk(mem.data[8'h83], 8'h80);
    chk(mem.data[8'h21], 8'h00);
    chk(mem.data[8'h81], 8'hFF);
    tally_and_finish();
  end
endmodule : mcu_alu_branch_control_exec_test
`default_nettype wire
